/* pkg/dcp_pkg.sv */
// Shared constants of the deviation clear block.
package dcp_pkg;

    // Register byte addresses.
    localparam logic [7:0] DCP_OFS_CLR_COND   = 8'h00;
    localparam logic [7:0] DCP_OFS_PHASE      = 8'h04;
    localparam logic [7:0] DCP_OFS_SOURCE     = 8'h08;
    localparam logic [7:0] DCP_OFS_ZPOL       = 8'h0C;
    localparam logic [7:0] DCP_OFS_DIV_NARROW = 8'h10;
    localparam logic [7:0] DCP_OFS_DIV_WIDE   = 8'h14;
    localparam logic [7:0] DCP_OFS_CLR_INPUT  = 8'h18;
    localparam logic [7:0] DCP_OFS_POS_ERROR  = 8'h1C;
    localparam logic [7:0] DCP_OFS_FB_POS     = 8'h20;
    localparam logic [7:0] DCP_OFS_STATUS     = 8'h24;

    // Reset values.
    localparam logic [15:0] DCP_RST_ZPOL       = 16'h0001;
    localparam logic [15:0] DCP_RST_DIV_NARROW = 16'h09C4;
    localparam logic [17:0] DCP_RST_DIV_WIDE   = 18'h00000;

    // Clear input configuration fields.
    localparam int DCP_CI_TERM_LSB = 0;
    localparam int DCP_CI_FUNC_LSB = 8;
    localparam int DCP_CI_SENSE    = 16;
    localparam int DCP_CI_EDGE_LSB = 17;
    localparam logic [7:0] DCP_FUNC_DEV_CLEAR = 8'h23;

    // Division counts.
    localparam logic [17:0] DCP_DIV_MIN        = 18'h00023;
    localparam logic [17:0] DCP_DIV_NARROW_MAX = 18'h07FFF;
    localparam int          DCP_DIV_WIDE_MAX   = 262143;

    // Output rate limits.
    localparam int DCP_CLK_HZ       = 125_000_000;
    localparam int DCP_QUAD_MAX_PPS = 2_000_000;
    localparam int DCP_OC_Z_MAX_PPS = 100_000;
    localparam int DCP_QUAD_EDGE_CYC =
        (DCP_CLK_HZ + 4 * DCP_QUAD_MAX_PPS - 1) / (4 * DCP_QUAD_MAX_PPS);
    localparam int DCP_OC_Z_CYC = (DCP_CLK_HZ + DCP_OC_Z_MAX_PPS - 1) / DCP_OC_Z_MAX_PPS;

    typedef enum logic [1:0] {
        DCP_CLR_NOT_RUN = 2'b00,
        DCP_CLR_FAULT   = 2'b01,
        DCP_CLR_INPUT   = 2'b10,
        DCP_CLR_RSVD    = 2'b11
    } dcp_clr_sel_t;

    typedef enum logic [1:0] {
        DCP_SRC_ENCODER = 2'b00,
        DCP_SRC_COMMAND = 2'b01,
        DCP_SRC_INHIBIT = 2'b10,
        DCP_SRC_RSVD    = 2'b11
    } dcp_src_t;

    typedef enum logic [1:0] {
        DCP_EDGE_LEVEL   = 2'b00,
        DCP_EDGE_RISING  = 2'b01,
        DCP_EDGE_FALLING = 2'b10,
        DCP_EDGE_RSVD    = 2'b11
    } dcp_edge_t;

endpackage : dcp_pkg

/* pkg/dcp_quad_if.sv */
// Step stream and pin levels for the quadrature generator.
`timescale 1ns/10ps
`default_nettype none
interface dcp_quad_if;
    logic step;
    logic dir;
    logic index_arm;
    logic enable;
    logic phase_swap;
    logic a;
    logic b;
    logic z;

    modport src (output step, output dir, output index_arm, output enable,
                 output phase_swap, input a, input b, input z);
    modport gen (input step, input dir, input index_arm, input enable,
                 input phase_swap, output a, output b, output z);
endinterface : dcp_quad_if
`default_nettype wire

/* rtl/dcp_quad_gen.sv */
// Rate-limited quadrature A/B/Z generator fed by single steps.
`timescale 1ns/10ps
`default_nettype none
module dcp_quad_gen
    import dcp_pkg::*;
#(
    parameter int PEND_W = 8
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Step stream in, pin levels out.
    dcp_quad_if.gen   q
);

    localparam logic [PEND_W-1:0] PEND_MAX = {1'b0, {(PEND_W-1){1'b1}}};
    localparam logic [PEND_W-1:0] PEND_MIN = {1'b1, {(PEND_W-1){1'b0}}};
    localparam logic [7:0]        GAP_CYC  = 8'(DCP_QUAD_EDGE_CYC - 1);

    logic signed [PEND_W-1:0] pending;
    logic [7:0]               gap;
    logic [1:0]               phase;
    logic [2:0]               z_left;
    logic                     z_armed;
    logic                     emit;
    logic                     emit_fwd;
    logic [1:0]               next_phase;

    assign emit       = q.enable && (gap == 8'h00) && (pending != '0);
    assign emit_fwd   = !pending[PEND_W-1];
    assign next_phase = emit_fwd ? phase + 2'h1 : phase - 2'h1;

    // Steps beyond the counter range are dropped.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= '0;
        end else if (!q.enable) begin
            pending <= '0;
        end else begin
            if (q.step && q.dir && !emit_fwd && emit) begin
                pending <= pending + PEND_W'(2);
            end else if (q.step && !q.dir && emit_fwd && emit) begin
                pending <= pending - PEND_W'(2);
            end else if (q.step && q.dir && !emit && pending != PEND_MAX) begin
                pending <= pending + PEND_W'(1);
            end else if (q.step && !q.dir && !emit && pending != PEND_MIN) begin
                pending <= pending - PEND_W'(1);
            end else if (emit && !(q.step && (q.dir == emit_fwd))) begin
                pending <= emit_fwd ? pending - PEND_W'(1) : pending + PEND_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap <= 8'h00;
        end else if (emit) begin
            gap <= GAP_CYC;
        end else if (gap != 8'h00) begin
            gap <= gap - 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 2'h0;
        end else if (emit) begin
            phase <= next_phase;
        end
    end

    // Index opens on the next step into phase 1, an A rise only going forward without swap, and lasts one full A/B period.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            z_armed <= 1'b0;
            z_left  <= 3'h0;
        end else if (!q.enable) begin
            z_armed <= 1'b0;
            z_left  <= 3'h0;
        end else if (emit && z_armed && next_phase == 2'h1) begin
            z_armed <= q.index_arm;
            z_left  <= 3'h4;
        end else begin
            z_armed <= z_armed || q.index_arm;
            if (emit && z_left != 3'h0) begin
                z_left <= z_left - 3'h1;
            end
        end
    end

    // With the swap, B takes the A waveform so the lead reverses.
    always_comb begin
        logic a_raw;
        logic b_raw;
        a_raw = (phase == 2'h1) || (phase == 2'h2);
        b_raw = (phase == 2'h2) || (phase == 2'h3);
        q.a   = q.phase_swap ? b_raw : a_raw;
        q.b   = q.phase_swap ? a_raw : b_raw;
        q.z   = (z_left != 3'h0);
    end

endmodule : dcp_quad_gen
`default_nettype wire

/* rtl/dcp_top.sv */
// Deviation clear and pulse output with an AHB-Lite slave.
//
// Overview of operation
// - Select 0 clears if off or not running.
// - Select 1 clears if off, faulted or warned.
// - Select 2 clears if off or input valid.
// - Clear input is a terminal at function 35.
// - Valid input clears; invalid does nothing.
// - Clear input may be edge sensitive.
// - Output shows command or feedback as quadrature.
// - Source 1 re-emits commands, 0 divides encoder.
// - Encoder mode emits count periods per turn.
// - Index once per turn, A aligned, one period.
// - Phase order 0 A leads forward; 1 swaps.
// - A/B/Z at most 2 Mpps, open collector 100 kpps.
// - Full closed loop makes the pins inputs.
// - Source 2 inhibits both output kinds.
// - Index polarity 0 active high, 1 active low.
// - Wide count below 35 uses narrow count.
`timescale 1ns/10ps
`default_nettype none
module dcp_top
    import dcp_pkg::*;
#(
    parameter int ENC_RES   = 1048576,
    parameter int N_TERM    = 9,
    parameter int PEND_W    = 8
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Servo state.
    input  wire logic        servo_enable,
    input  wire logic        servo_running,
    input  wire logic        servo_fault,
    input  wire logic        servo_warning,
    input  wire logic        full_closed_loop,
    // Digital input terminals.
    input  wire logic [N_TERM-1:0] di_terminal,
    // Position command pulses.
    input  wire logic        cmd_step,
    input  wire logic        cmd_dir,
    // Encoder feedback counts.
    input  wire logic        enc_step,
    input  wire logic        enc_dir,
    input  wire logic        enc_index,
    // Quadrature pins: input, output, active low enable.
    input  wire logic        quad_a_in,
    output logic             quad_a_out,
    output logic             quad_a_oe_n,
    input  wire logic        quad_b_in,
    output logic             quad_b_out,
    output logic             quad_b_oe_n,
    input  wire logic        index_in_differential,
    output logic             index_out_differential,
    output logic             index_out_differential_oe_n,
    // Open collector index pin.
    output logic             index_out_open_collector,
    output logic             index_out_open_collector_oe_n,
    // Deviation state.
    output logic             deviation_clear_active,
    output logic      [31:0] position_error
);

    if (ENC_RES < 4 * DCP_DIV_WIDE_MAX || ENC_RES > 1048576 || N_TERM < 1 || N_TERM > 16 ||
        PEND_W < 3) begin : g_chk
        $error("dcp_top: parameter out of range");
    end

    localparam logic [20:0] ENC_RES_W = 21'(ENC_RES);
    localparam logic [10:0] OC_GAP    = 11'(DCP_OC_Z_CYC - 1);

    function automatic logic [31:0] step_delta(input logic step, input logic dir);
        step_delta = !step ? 32'h0000_0000 : (dir ? 32'h0000_0001 : 32'hFFFF_FFFF);
    endfunction : step_delta

    function automatic logic pick_bit(input logic [N_TERM-1:0] v, input logic [3:0] idx);
        pick_bit = (32'(idx) < N_TERM) ? v[idx] : 1'b0;
    endfunction : pick_bit

    // Registers.
    dcp_clr_sel_t deviation_clear_condition;
    logic         pulse_output_phase_order;
    dcp_src_t     pulse_output_source;
    logic         z_polarity_select;
    logic [15:0]  narrow_division_count;
    logic [17:0]  wide_division_count;
    logic [18:0]  clear_input_config;

    // Bus phase capture.
    logic         dp_write;
    logic [7:0]   dp_addr;

    // Position state.
    logic [31:0]  cmd_pos;
    logic [31:0]  fb_pos;
    logic [31:0]  next_fb_pos;

    // Clear input.
    logic         term_level;
    logic         term_prev;
    logic         clr_input_valid;
    logic         clr_now;

    // Pulse output.
    logic [17:0]  division_count;
    logic [20:0]  div_acc;
    logic [20:0]  next_div_acc;
    logic         div_emit;
    logic [10:0]  oc_gap;
    logic         oc_z;
    logic         gen_z_prev;
    logic         z_level;

    dcp_quad_if   quad ();

    // Bus slave: zero wait, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else if (hready) begin
            dp_write <= hsel && htrans[1] && hwrite && (hsize == 3'h2) && (haddr[31:8] == 24'h0);
            dp_addr  <= haddr[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (haddr[31:8] != 24'h0) begin
                hrdata <= 32'h0000_0000;
            end else begin
                unique case (haddr[7:0])
                    DCP_OFS_CLR_COND:   hrdata <= {30'h0, deviation_clear_condition};
                    DCP_OFS_PHASE:      hrdata <= {31'h0, pulse_output_phase_order};
                    DCP_OFS_SOURCE:     hrdata <= {30'h0, pulse_output_source};
                    DCP_OFS_ZPOL:       hrdata <= {31'h0, z_polarity_select};
                    DCP_OFS_DIV_NARROW: hrdata <= {16'h0, narrow_division_count};
                    DCP_OFS_DIV_WIDE:   hrdata <= {14'h0, wide_division_count};
                    DCP_OFS_CLR_INPUT:  hrdata <= {13'h0, clear_input_config};
                    DCP_OFS_POS_ERROR:  hrdata <= position_error;
                    DCP_OFS_FB_POS:     hrdata <= fb_pos;
                    DCP_OFS_STATUS:     hrdata <= {25'h0, index_in_differential, quad_b_in,
                                                   quad_a_in, full_closed_loop, term_level,
                                                   clr_input_valid, clr_now};
                    default:            hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration writes land in the data phase.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            deviation_clear_condition <= DCP_CLR_NOT_RUN;
            pulse_output_phase_order  <= 1'b0;
            pulse_output_source       <= DCP_SRC_ENCODER;
            z_polarity_select         <= DCP_RST_ZPOL[0];
            narrow_division_count     <= DCP_RST_DIV_NARROW;
            wide_division_count       <= DCP_RST_DIV_WIDE;
            clear_input_config        <= 19'h0;
        end else if (dp_write) begin
            unique case (dp_addr)
                DCP_OFS_CLR_COND:   deviation_clear_condition <= dcp_clr_sel_t'(hwdata[1:0]);
                DCP_OFS_PHASE:      pulse_output_phase_order  <= hwdata[0];
                DCP_OFS_SOURCE:     pulse_output_source       <= dcp_src_t'(hwdata[1:0]);
                DCP_OFS_ZPOL:       z_polarity_select         <= hwdata[0];
                DCP_OFS_DIV_NARROW: narrow_division_count     <= hwdata[15:0];
                DCP_OFS_DIV_WIDE:   wide_division_count       <= hwdata[17:0];
                DCP_OFS_CLR_INPUT:  clear_input_config        <= hwdata[18:0];
                default:            ;
            endcase
        end
    end

    // Clear input from the mapped terminal.
    assign term_level = pick_bit(di_terminal,
                                 clear_input_config[DCP_CI_TERM_LSB +: 4]);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            term_prev <= 1'b0;
        end else begin
            term_prev <= term_level;
        end
    end

    always_comb begin
        logic mapped;
        logic sense;
        mapped = (clear_input_config[DCP_CI_FUNC_LSB +: 8] == DCP_FUNC_DEV_CLEAR);
        sense  = clear_input_config[DCP_CI_SENSE];
        unique case (dcp_edge_t'(clear_input_config[DCP_CI_EDGE_LSB +: 2]))
            DCP_EDGE_RISING:  clr_input_valid = mapped && term_level && !term_prev;
            DCP_EDGE_FALLING: clr_input_valid = mapped && !term_level && term_prev;
            default:          clr_input_valid = mapped && (term_level == sense);
        endcase
    end

    // A reserved select behaves as select 0.
    always_comb begin
        unique case (deviation_clear_condition)
            DCP_CLR_FAULT: clr_now = !servo_enable || servo_fault || servo_warning;
            DCP_CLR_INPUT: clr_now = !servo_enable || clr_input_valid;
            default:       clr_now = !servo_enable || !servo_running;
        endcase
    end

    assign deviation_clear_active = clr_now;

    // Positions in encoder units; the error is command minus feedback.
    assign next_fb_pos = fb_pos + step_delta(enc_step, enc_dir);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fb_pos <= 32'h0000_0000;
        end else begin
            fb_pos <= next_fb_pos;
        end
    end

    // Taking this cycle's feedback step keeps the error at zero after a clear.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_pos <= 32'h0000_0000;
        end else if (clr_now) begin
            cmd_pos <= next_fb_pos;
        end else begin
            cmd_pos <= cmd_pos + step_delta(cmd_step, cmd_dir);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            position_error <= 32'h0000_0000;
        end else if (clr_now) begin
            position_error <= 32'h0000_0000;
        end else begin
            position_error <= cmd_pos + step_delta(cmd_step, cmd_dir) - next_fb_pos;
        end
    end

    // Narrow count clamped to its range unless the wide one is set.
    always_comb begin
        logic [17:0] narrow;
        narrow = {2'h0, narrow_division_count};
        if (narrow < DCP_DIV_MIN) begin
            narrow = DCP_DIV_MIN;
        end else if (narrow > DCP_DIV_NARROW_MAX) begin
            narrow = DCP_DIV_NARROW_MAX;
        end
        division_count = (wide_division_count < DCP_DIV_MIN) ? narrow
                                                             : wide_division_count;
    end

    // Each encoder count adds four times the division count; a full turn wraps.
    always_comb begin
        logic [20:0] sum;
        sum          = div_acc + {1'b0, division_count, 2'b00};
        div_emit     = enc_step && (sum >= ENC_RES_W);
        next_div_acc = div_emit ? sum - ENC_RES_W : sum;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_acc <= 21'h0;
        end else if (pulse_output_source != DCP_SRC_ENCODER) begin
            div_acc <= 21'h0;
        end else if (enc_step) begin
            div_acc <= next_div_acc;
        end
    end

    // Source select feeds the generator.
    always_comb begin
        quad.enable     = !full_closed_loop && (pulse_output_source == DCP_SRC_ENCODER ||
                          pulse_output_source == DCP_SRC_COMMAND);
        quad.phase_swap = pulse_output_phase_order;
        unique case (pulse_output_source)
            DCP_SRC_ENCODER: begin
                quad.step      = div_emit;
                quad.dir       = enc_dir;
                quad.index_arm = enc_index;
            end
            DCP_SRC_COMMAND: begin
                quad.step      = cmd_step;
                quad.dir       = cmd_dir;
                quad.index_arm = 1'b0;
            end
            default: begin
                quad.step      = 1'b0;
                quad.dir       = 1'b0;
                quad.index_arm = 1'b0;
            end
        endcase
    end

    dcp_quad_gen #(
        .PEND_W  (PEND_W)
    ) u_gen (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .q       (quad)
    );

    // The slow pin only starts when its own spacing allows.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gen_z_prev <= 1'b0;
            oc_gap     <= 11'h0;
            oc_z       <= 1'b0;
        end else begin
            gen_z_prev <= quad.z;
            if (quad.z && !gen_z_prev && oc_gap == 11'h0) begin
                oc_z   <= 1'b1;
                oc_gap <= OC_GAP;
            end else begin
                if (!quad.z) begin
                    oc_z <= 1'b0;
                end
                if (oc_gap != 11'h0) begin
                    oc_gap <= oc_gap - 11'h1;
                end
            end
        end
    end

    // In full closed loop the pins turn into scale inputs.
    assign z_level = z_polarity_select ? !quad.z : quad.z;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            quad_a_out                    <= 1'b0;
            quad_b_out                    <= 1'b0;
            index_out_differential        <= 1'b0;
            quad_a_oe_n                   <= 1'b1;
            quad_b_oe_n                   <= 1'b1;
            index_out_differential_oe_n   <= 1'b1;
            index_out_open_collector_oe_n <= 1'b1;
        end else begin
            quad_a_out                    <= quad.a;
            quad_b_out                    <= quad.b;
            index_out_differential        <= z_level;
            quad_a_oe_n                   <= full_closed_loop;
            quad_b_oe_n                   <= full_closed_loop;
            index_out_differential_oe_n   <= full_closed_loop;
            index_out_open_collector_oe_n <= full_closed_loop ||
                                             !(z_polarity_select ? oc_z : !oc_z);
        end
    end

    // Open collector only pulls low; released means high.
    assign index_out_open_collector = 1'b0;

endmodule : dcp_top
`default_nettype wire

/* sim/dcp_top_checker.sv */
// Assertions on the ports of the deviation clear block.
`timescale 1ns/10ps
`default_nettype none
module dcp_top_checker (
    // Watched ports.
    input wire logic        sys_clk, reset_n, servo_enable, full_closed_loop, hreadyout, hresp,
    input wire logic        quad_a_out, quad_b_out, quad_a_oe_n, quad_b_oe_n,
    input wire logic        index_out_differential_oe_n, deviation_clear_active,
    input wire logic [31:0] position_error
);
    logic [4:0] gap;
    logic       last_a;
    logic       last_b;
    // Saturating, so long idle spans never wrap.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap <= 5'h1F;
            last_a <= 1'b0;
            last_b <= 1'b0;
        end else begin
            last_a <= quad_a_out;
            last_b <= quad_b_out;
            gap <= (quad_a_out != last_a || quad_b_out != last_b) ? 5'h00 :
                   (gap == 5'h1F) ? gap : gap + 5'h01;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_off_clears: assert property (!servo_enable |-> deviation_clear_active)
        else $error("servo off without clear");
    a_clear_zeroes: assert property (deviation_clear_active |=> position_error == 32'h0)
        else $error("error not zero after clear");
    a_loop_releases: assert property (full_closed_loop |=> quad_a_oe_n && quad_b_oe_n
        && index_out_differential_oe_n) else $error("pins driven in closed loop");
    a_pins_driven: assert property (!full_closed_loop |=> !quad_a_oe_n && !quad_b_oe_n)
        else $error("pins not driven");
    a_one_phase: assert property ($changed(quad_a_out) |-> $stable(quad_b_out))
        else $error("both phases moved at once");
    a_edge_gap: assert property ($changed(quad_a_out) || $changed(quad_b_out) |-> gap >= 5'd15)
        else $error("pin edges too close");
    a_loop_silent: assert property (full_closed_loop [*3] |=> $stable(quad_a_out))
        else $error("edge in closed loop");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule : dcp_top_checker
bind dcp_top dcp_top_checker u_chk (.*);
`default_nettype wire

/* sim/dcp_host_model.sv */
// Host that counts the quadrature edges it receives.
`timescale 1ns/10ps
`default_nettype none
module dcp_host_model (
    // Clock and received pin levels.
    input  wire logic sys_clk,
    input  wire logic pin_a,
    input  wire logic pin_b,
    // Signed count of decoded edges.
    output int        count
);
    logic last_a = 1'b0;
    logic last_b = 1'b0;
    initial count = 0;
    // Forward when the new A level differs from the old B level.
    always @(posedge sys_clk) begin
        if (pin_a != last_a || pin_b != last_b) begin
            count <= count + ((pin_a ^ last_b) ? 1 : -1);
        end
        last_a <= pin_a;
        last_b <= pin_b;
    end
endmodule : dcp_host_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the deviation clear block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dcp_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, hwrite = 1'b0, cmd_step = 1'b0, enc_step = 1'b0;
    logic servo_enable = 1'b0, servo_running = 1'b0, servo_fault = 1'b0, servo_warning = 1'b0;
    logic full_closed_loop = 1'b0, hreadyout, hresp, deviation_clear_active, z_out, z_oe_n;
    logic quad_a_out, quad_a_oe_n, quad_b_out, quad_b_oe_n;
    logic [1:0] htrans = 2'h0;
    logic [8:0] di_terminal = 9'h000;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, position_error, rd, r, seed = 32'd93151;
    logic [7:0] ra[7] = '{DCP_OFS_CLR_COND, DCP_OFS_PHASE, DCP_OFS_SOURCE, DCP_OFS_ZPOL,
                          DCP_OFS_DIV_NARROW, DCP_OFS_DIV_WIDE, 8'h40};
    logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h9C4, 32'h0, 32'h0};
    int miscompares = 0, checked = 0, count, base;
    // Released pins rest high on pull-ups.
    wire logic wire_a = quad_a_oe_n ? 1'b1 : quad_a_out;
    wire logic wire_b = quad_b_oe_n ? 1'b1 : quad_b_out;
    wire logic wire_z = z_oe_n ? 1'b1 : z_out;
    always #4 sys_clk = ~sys_clk;
    dcp_top u_dut (.*, .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .cmd_dir(1'b1),
        .enc_dir(1'b1), .enc_index(1'b0), .quad_a_in(wire_a), .quad_b_in(wire_b),
        .index_in_differential(wire_z), .index_out_differential(z_out),
        .index_out_differential_oe_n(z_oe_n), .index_out_open_collector(),
        .index_out_open_collector_oe_n());
    dcp_host_model u_host (.sys_clk, .pin_a(wire_a), .pin_b(wire_b), .count);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Inputs v are terminal 7, warning, fault, running and enable.
    function automatic logic exp_clear(input logic [1:0] s, input logic [4:0] v);
        if (!v[0]) return 1'b1;
        return (s == 2'h1) ? (v[2] | v[3]) : (s == 2'h2) ? v[4] : !v[1];
    endfunction : exp_clear
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic ready();
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask : ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        ready();
        htrans <= 2'h0;
        hwdata <= d;
        ready();
        rd = hrdata;
    endtask : bus
    // Command steps spaced so the generator keeps pace at its rate ceiling; divided encoder steps can run ahead and drain in the tail.
    task automatic pulse(input logic enc, input int gap, input logic [31:0] n, e);
        repeat (n) begin
            {enc_step, cmd_step} <= enc ? 2'b10 : 2'b01;
            @(posedge sys_clk);
            {enc_step, cmd_step} <= 2'b00;
            repeat (gap) @(posedge sys_clk);
        end
        repeat (300) @(posedge sys_clk);
        chk(32'(count - base), e);
    endtask : pulse
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        bus(1'b1, DCP_OFS_CLR_INPUT, 32'h0001_2307);
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            bus(1'b1, DCP_OFS_CLR_COND, {30'h0, r[1:0]});
            {di_terminal, servo_warning, servo_fault, servo_running, servo_enable} <= r[14:2];
            @(posedge sys_clk);
            chk(32'(deviation_clear_active), 32'(exp_clear(r[1:0], {r[13], r[5:2]})));
        end
        bus(1'b1, DCP_OFS_CLR_COND, 32'h0);
        {di_terminal, servo_warning, servo_fault, servo_running} <= 12'h001;
        for (int m = 0; m < 5; m++) begin
            r = rnd() % 8 * 2 + 2;
            bus(1'b1, DCP_OFS_SOURCE, 32'(m == 2 || m == 3 ? m : 1));
            bus(1'b1, DCP_OFS_PHASE, {31'h0, m == 1});
            full_closed_loop <= (m == 4);
            servo_enable <= 1'b0;
            @(posedge sys_clk);
            servo_enable <= 1'b1;
            repeat (20) @(posedge sys_clk);
            base = count;
            pulse(1'b0, 20, m > 1 ? 7 : r, m == 1 ? -r : m > 1 ? 0 : r);
            if (m == 0) chk(position_error, r);
        end
        full_closed_loop <= 1'b0;
        bus(1'b1, DCP_OFS_SOURCE, 32'h0);
        for (int k = 0; k < 2; k++) begin
            r = 35 + rnd() % 32733;
            bus(1'b1, DCP_OFS_DIV_NARROW, r);
            bus(1'b1, DCP_OFS_DIV_WIDE, k ? 32'h22 : 32'h1_0000);
            repeat (20) @(posedge sys_clk);
            base = count;
            pulse(1'b1, 2, 40, 160 * (k ? r : 32'h1_0000) / 1048576);
        end
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
